// ==== design/accel_reg_cfg.svh ====
// register map, field positions, reset values and timing for the accelerometer register bank
`ifndef ACCEL_REG_CFG_SVH
`define ACCEL_REG_CFG_SVH

// register addresses, six bits on the serial link
`define ADDR_W          6
`define ADDR_CTRL       6'h01
`define ADDR_STATUS     6'h02
`define ADDR_X_LSB      6'h04
`define ADDR_X_MSB      6'h05
`define ADDR_Y_LSB      6'h06
`define ADDR_Y_MSB      6'h07
`define ADDR_Z_LSB      6'h08
`define ADDR_Z_MSB      6'h09
`define ADDR_THERMO_LO  6'h0c
`define ADDR_THERMO_HI  6'h0d
`define ADDR_EVENT      6'h10
`define ADDR_PART_CODE  6'h1b

// field positions
`define EVT_OVERRANGE_BIT  6
`define EVT_GRAV_FAIL_BIT  5
`define EVT_RUN_FAIL_BIT   4
`define STAT_CSUM_BIT      1
`define RSP_OVERRANGE_BIT  6
`define RSP_FAULT_BIT      5
`define RSP_POWER_ON_RESET_FLAG_BIT      3

// reset values
`define CTRL_RESET       8'h40
`define OVERRANGE_RESET  1'b1
`define PART_CODE_RESET  8'h5a

// frame length and memory self check duration
`define FRAME_BITS     5'h10
`define CMD_BITS       5'h08
`define CLK_PERIOD_NS  4
`define MEM_CHECK_NS   85000
`define MEM_CNT_W      15

`endif

// ==== design/accel_reg_pkg.sv ====
// types shared by the accelerometer register bank and its serial shifter
package accel_reg_pkg;

  // control register layout, msb first
  typedef struct packed {
    logic rsv;
    logic power_on_reset_flag;
    logic power_down_ctl;
    logic sleep;
    logic health;
    logic mem_go;
    logic grav_go;
    logic miso_iso;
  } ctrl_t;

  // command byte of a frame
  typedef struct packed {
    logic [5:0] addr;
    logic       wr;
    logic       rsv;
  } spi_cmd_t;

  // sensor path samples, 13 bits each, axes in two's complement
  typedef struct packed {
    logic signed [12:0] accel_x;
    logic signed [12:0] accel_y;
    logic signed [12:0] accel_z;
    logic        [12:0] thermo;
  } sample_t;

endpackage

// ==== design/spi_frame_shifter.sv ====
// serial frame shifter: 16-bit frames, sample on sck rise, shift out on sck fall
`timescale 1ns/1ps
`include "accel_reg_cfg.svh"

module spi_frame_shifter
  import accel_reg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        sck_in,
  input  wire logic        mosi_in,
  input  wire logic        cs_n_in,
  input  wire logic        accept_in,
  input  wire logic        drive_in,
  input  wire logic [7:0]  status_byte_in,
  input  wire logic [7:0]  resp_byte_in,
  output logic             cmd_valid_out,
  output logic             frame_done_out,
  output logic [15:0]      frame_out,
  output logic             miso_out,
  output logic             miso_oe_out
);

  logic       sck_q;
  logic       cs_n_q;
  logic       active_q;
  logic [4:0] cnt_q;
  logic [7:0] tx_q;

  // edge and frame start decode
  wire sck_rise = sck_in & ~sck_q;
  wire sck_fall = ~sck_in & sck_q;
  wire start    = ~cs_n_in & cs_n_q & accept_in;
  wire active_d = ~cs_n_in & (active_q | start);
  wire shift_in = sck_rise & active_q & (cnt_q < `FRAME_BITS);

  // receive side, count and pulses
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sck_q          <= 1'b0;
      cs_n_q         <= 1'b1;
      active_q       <= 1'b0;
      cnt_q          <= 5'h00;
      frame_out      <= 16'h0000;
      cmd_valid_out  <= 1'b0;
      frame_done_out <= 1'b0;
    end else begin
      sck_q          <= sck_in;
      cs_n_q         <= cs_n_in;
      active_q       <= active_d;
      cnt_q          <= start ? 5'h00 : (shift_in ? cnt_q + 5'h01 : cnt_q);
      frame_out      <= shift_in ? {frame_out[14:0], mosi_in} : frame_out;
      cmd_valid_out  <= shift_in & (cnt_q == `CMD_BITS - 5'h01);
      frame_done_out <= shift_in & (cnt_q == `FRAME_BITS - 5'h01);
    end
  end

  // transmit side: status byte first, then the read byte
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_q        <= 8'h00;
      miso_out    <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      miso_oe_out <= active_d & drive_in;
      if (start) begin
        miso_out <= status_byte_in[7];
        tx_q     <= {status_byte_in[6:0], 1'b0};
      end else if (sck_fall & active_q & (cnt_q == `CMD_BITS)) begin
        miso_out <= resp_byte_in[7];
        tx_q     <= {resp_byte_in[6:0], 1'b0};
      end else if (sck_fall & active_q) begin
        miso_out <= tx_q[7];
        tx_q     <= {tx_q[6:0], 1'b0};
      end
    end
  end

endmodule

// ==== design/accel_register_control.sv ====
// accelerometer register bank: temperature, event flags, part code and control
`timescale 1ns/1ps
`include "accel_reg_cfg.svh"

// Behaviour
// - thermo high read latches thermo low byte
// - overrange flag shows axis saturation
// - overrange mirrored in frame; host acknowledges
// - gravity check failure flag, raises frame fault
// - running check failure flag, raises frame fault
// - event flags sticky until register read
// - part code writable, never stored permanently
// - axis words in two's complement
// - power-on flag set by reset, write-zero clears
// - power-on flag sent as response bit 3
// - power-down bit, resets to zero
// - sleep refused while power-down set or setting
// - health check refused by power, sleep, memory
// - memory check blocks link, then self-clears
// - memory check refused by power-down or sleep
// - memory check runs at start-up, reports
// - gravity check self-clears, same interlocks
// - isolate bit keeps serial output released
// - thermo 13 bits unsigned, split high/low
// - axis high read latches axis low byte
// - checksum error flag raises frame fault
module accel_register_control
  import accel_reg_pkg::*;
#(
  parameter int unsigned MEM_CHECK_CYCLES =
    (`MEM_CHECK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter logic [7:0]  PART_CODE_INIT   = `PART_CODE_RESET  // arbitrary value
)
(
  input  wire logic    clk_in,
  input  wire logic    sys_rst_in,
  input  wire logic    sck_in,
  input  wire logic    mosi_in,
  input  wire logic    cs_n_in,
  input  wire sample_t sample_in,
  input  wire logic    saturated_in,
  input  wire logic    gravity_done_in,
  input  wire logic    gravity_fail_in,
  input  wire logic    running_fail_in,
  input  wire logic    checksum_bad_in,
  output logic         miso_out,
  output logic         miso_oe_out,
  output logic         power_down_out,
  output logic         sleep_out,
  output logic         health_check_out,
  output logic         gravity_go_out,
  output logic         memory_check_busy_out
);

  localparam logic [`MEM_CNT_W-1:0] MEM_CNT_LOAD = MEM_CHECK_CYCLES[`MEM_CNT_W-1:0];

  ctrl_t                  ctrl_q;
  ctrl_t                  ctrl_d;
  ctrl_t                  ctrl_wr;
  ctrl_t                  ctrl_hold;
  logic                   ovr_q;
  logic                   grav_fail_q;
  logic                   run_fail_q;
  logic                   csum_err_q;
  logic [7:0]             part_code_q;
  logic [7:0]             resp_q;
  logic [`MEM_CNT_W-1:0]  mem_cnt_q;
  logic [7:0]             lsb_q [4];
  logic [12:0]            chan [4];
  logic                   cmd_valid;
  logic                   frame_done;
  logic [15:0]            frame;
  logic [7:0]             status_byte;
  logic [7:0]             rd_byte;

  // serial link
  spi_frame_shifter u_shifter (
    .clk_in         (clk_in),
    .sys_rst_in     (sys_rst_in),
    .sck_in         (sck_in),
    .mosi_in        (mosi_in),
    .cs_n_in        (cs_n_in),
    .accept_in      (~memory_check_busy_out),  // link blocked during memory
    .drive_in       (~ctrl_q.miso_iso),
    .status_byte_in (status_byte),
    .resp_byte_in   (resp_q),
    .cmd_valid_out  (cmd_valid),
    .frame_done_out (frame_done),
    .frame_out      (frame),
    .miso_out       (miso_out),
    .miso_oe_out    (miso_oe_out)
  );

  // command decode: read side effects at the command byte, writes at frame end
  spi_cmd_t cmd;
  assign cmd = spi_cmd_t'(frame[7:0]);
  spi_cmd_t wcmd;
  assign wcmd = spi_cmd_t'(frame[15:8]);
  wire [7:0] wd       = frame[7:0];
  wire       rd_cmd   = cmd_valid & ~cmd.wr;
  wire       wr_frame = frame_done & wcmd.wr;
  wire       wr_ctrl  = wr_frame & (wcmd.addr == `ADDR_CTRL);
  wire       wr_part  = wr_frame & (wcmd.addr == `ADDR_PART_CODE);
  wire       clr_evt  = rd_cmd & (cmd.addr == `ADDR_EVENT);
  wire       mem_busy = (mem_cnt_q != '0);
  wire       mem_done = (mem_cnt_q == {{(`MEM_CNT_W-1){1'b0}}, 1'b1});

  // sensor channels: x, y, z in two's complement, thermo unsigned
  assign chan[0] = sample_in.accel_x;
  assign chan[1] = sample_in.accel_y;
  assign chan[2] = sample_in.accel_z;
  assign chan[3] = sample_in.thermo;

  localparam logic [`ADDR_W-1:0] MSB_ADDR [4] =
    '{`ADDR_X_MSB, `ADDR_Y_MSB, `ADDR_Z_MSB, `ADDR_THERMO_HI};

  // a high byte read captures the low half of the same sample
  for (genvar i = 0; i < 4; i++) begin : g_latch
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        lsb_q[i] <= 8'h00;
      end else if (rd_cmd & (cmd.addr == MSB_ADDR[i])) begin
        lsb_q[i] <= {chan[i][6:0], 1'b0};  // bit 0 unused
      end
    end
  end

  // register read values, reserved bits zero
  wire [7:0] evt_byte  = {1'b0, ovr_q, grav_fail_q, run_fail_q, 4'h0};
  wire [7:0] stat_byte = {6'h00, csum_err_q, 1'b0};
  wire [7:0] ctrl_byte = {1'b0, ctrl_q[6:0]};
  function automatic logic [7:0] hi_byte(input logic [12:0] s);
    hi_byte = {2'b00, s[12:7]};
  endfunction

  // read selection
  assign rd_byte =
    (cmd.addr == `ADDR_CTRL)      ? ctrl_byte :
    (cmd.addr == `ADDR_STATUS)    ? stat_byte :
    (cmd.addr == `ADDR_X_LSB)     ? lsb_q[0] :
    (cmd.addr == `ADDR_X_MSB)     ? hi_byte(chan[0]) :
    (cmd.addr == `ADDR_Y_LSB)     ? lsb_q[1] :
    (cmd.addr == `ADDR_Y_MSB)     ? hi_byte(chan[1]) :
    (cmd.addr == `ADDR_Z_LSB)     ? lsb_q[2] :
    (cmd.addr == `ADDR_Z_MSB)     ? hi_byte(chan[2]) :
    (cmd.addr == `ADDR_THERMO_LO) ? lsb_q[3] :
    (cmd.addr == `ADDR_THERMO_HI) ? hi_byte(chan[3]) :
    (cmd.addr == `ADDR_EVENT)     ? evt_byte :
    (cmd.addr == `ADDR_PART_CODE) ? part_code_q :
                                    8'h00;

  // response status byte sent first in every frame
  wire fault = grav_fail_q | run_fail_q | csum_err_q;
  assign status_byte = (8'h01 << `RSP_OVERRANGE_BIT) & {8{ovr_q}}
                     | (8'h01 << `RSP_FAULT_BIT) & {8{fault}}
                     | (8'h01 << `RSP_POWER_ON_RESET_FLAG_BIT) & {8{ctrl_q.power_on_reset_flag}};

  // response byte captured at the command byte
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      resp_q <= 8'h00;
    end else if (rd_cmd) begin
      resp_q <= rd_byte;
    end
  end

  // sticky event flags: set wins over the read acknowledgement
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ovr_q       <= `OVERRANGE_RESET;  // settling after reset
      grav_fail_q <= 1'b0;
      run_fail_q  <= 1'b0;
    end else begin
      ovr_q       <= saturated_in | (ovr_q & ~clr_evt);
      grav_fail_q <= (gravity_done_in & gravity_fail_in) | (grav_fail_q & ~clr_evt);
      run_fail_q  <= running_fail_in | (run_fail_q & ~clr_evt);
    end
  end

  // part code: volatile copy only, nothing goes back to storage
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      part_code_q <= PART_CODE_INIT;
    end else if (wr_part) begin
      part_code_q <= wd;
    end
  end

  // control write interlocks; a refused set leaves the bit at zero
  wire pd_set  = wd[5];
  wire sl_req  = wd[4] & ~ctrl_q.power_down_ctl & ~pd_set;
  wire pwr_blk = ctrl_q.power_down_ctl | ctrl_q.sleep | pd_set | sl_req;
  wire mem_req = wd[2] & ~pwr_blk;
  wire chk_blk = pwr_blk | ctrl_q.mem_go | mem_req;
  assign ctrl_wr = '{rsv:      1'b0,
                     power_on_reset_flag:    ctrl_q.power_on_reset_flag & wd[6],
                     power_down_ctl:     pd_set,
                     sleep:    sl_req,
                     health:   wd[3] & ~chk_blk,
                     mem_go:   mem_req,
                     grav_go:  wd[1] & ~chk_blk,
                     miso_iso: wd[0]};

  // self-clearing launch bits when their checks end
  always_comb begin
    ctrl_hold         = ctrl_q;
    ctrl_hold.mem_go  = ctrl_q.mem_go & ~mem_done;
    ctrl_hold.grav_go = ctrl_q.grav_go & ~gravity_done_in;
  end
  assign ctrl_d = wr_ctrl ? ctrl_wr : ctrl_hold;

  // control register; reset raises the power-on flag
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_q <= ctrl_t'(`CTRL_RESET);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // memory check timer, loaded at reset and on launch
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mem_cnt_q             <= MEM_CNT_LOAD;
      csum_err_q            <= 1'b0;
      memory_check_busy_out <= 1'b1;
    end else begin
      if (wr_ctrl & mem_req) begin
        mem_cnt_q <= MEM_CNT_LOAD;
      end else if (mem_busy) begin
        mem_cnt_q <= mem_cnt_q - {{(`MEM_CNT_W-1){1'b0}}, 1'b1};
      end
      if (mem_done) begin
        csum_err_q <= checksum_bad_in;  // result of the
      end
      memory_check_busy_out <= (wr_ctrl & mem_req) | (mem_busy & ~mem_done);
    end
  end

  // mode outputs straight from the control flops
  assign power_down_out   = ctrl_q.power_down_ctl;
  assign sleep_out        = ctrl_q.sleep;
  assign health_check_out = ctrl_q.health;
  assign gravity_go_out   = ctrl_q.grav_go;

  // checks
  thermo_latch_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    rd_cmd && cmd.addr == `ADDR_THERMO_HI |=> lsb_q[3] == {$past(chan[3][6:0]), 1'b0})
    else $error("thermo low byte not captured on high read");

  axis_latch_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    rd_cmd && cmd.addr == `ADDR_Y_MSB |=> lsb_q[1] == {$past(chan[1][6:0]), 1'b0})
    else $error("axis low byte not captured on high read");

  overrange_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    saturated_in |=> ovr_q ##1 (ovr_q || $past(clr_evt)))
    else $error("overrange flag lost");

  event_ack_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clr_evt && !saturated_in && !running_fail_in |=> !ovr_q && !run_fail_q)
    else $error("event flags not cleared by read");

  fault_bit_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    running_fail_in |=> status_byte[`RSP_FAULT_BIT])
    else $error("running check failure missing from frame fault");

  power_on_reset_flag_keep_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ctrl_q.power_on_reset_flag |=> !ctrl_q.power_on_reset_flag)
    else $error("power-on flag set without reset");

  sleep_lock_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_ctrl && (ctrl_q.power_down_ctl || wd[5]) |=> !ctrl_q.sleep)
    else $error("sleep accepted under power-down");

  check_lock_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_ctrl && (ctrl_q.power_down_ctl || ctrl_q.sleep || wd[2]) |=> !ctrl_q.health && !ctrl_q.grav_go)
    else $error("self check launched against interlock");

  mem_block_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(ctrl_q.mem_go) |-> memory_check_busy_out [*8])
    else $error("link not blocked during memory check");

  mem_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(memory_check_busy_out) |-> !ctrl_q.mem_go)
    else $error("memory check bit not cleared at end");

  miso_iso_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctrl_q.miso_iso ##1 ctrl_q.miso_iso |-> !miso_oe_out)
    else $error("serial output driven while isolated");

  part_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_part |=> part_code_q == $past(wd))
    else $error("part code write lost");

  grav_flag_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    gravity_done_in && gravity_fail_in |=> grav_fail_q && status_byte[`RSP_FAULT_BIT])
    else $error("gravity check failure not flagged");

  mem_lock_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_ctrl && (ctrl_q.power_down_ctl || ctrl_q.sleep || wd[5] || wd[4]) |=> !ctrl_q.mem_go)
    else $error("memory check launched under power mode");

  power_down_ctl_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_ctrl |=> ctrl_q.power_down_ctl == $past(wd[5]))
    else $error("power-down bit not written");

  rsv_zero_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_ctrl |=> !ctrl_q.rsv)
    else $error("reserved control bit took a write");

  grav_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    gravity_done_in && !wr_ctrl |=> !ctrl_q.grav_go)
    else $error("gravity check bit not cleared at end");

  miso_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cs_n_in |=> !miso_oe_out)
    else $error("serial output driven between frames");

  frame_refuse_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(cs_n_in) && memory_check_busy_out |=> !miso_oe_out)
    else $error("frame accepted during memory check");

  power_on_reset_flag_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_ctrl && !wd[6] |=> !ctrl_q.power_on_reset_flag)
    else $error("power-on flag not cleared by write");

  csum_result_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    mem_done |=> csum_err_q == $past(checksum_bad_in))
    else $error("memory check result not reported");

  event_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    grav_fail_q && !clr_evt |=> grav_fail_q)
    else $error("gravity failure flag dropped without read");

  refuse_apply_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_ctrl && wd[5] && wd[4] |=> ctrl_q.power_down_ctl && !ctrl_q.sleep)
    else $error("refused write not applied in part");

endmodule

// ==== sim/spi_host_model.sv ====
// serial host model: drives 16-bit mode-0 frames and collects the reply
`timescale 1ns/1ps

module spi_host_model (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output logic      sck_out,
  output logic      mosi_out,
  output logic      cs_n_out
);
  localparam int HALF = 4;  // clk cycles per sck phase, above the 2-cycle minimum

  // idle: deselected, clock parked low, data at its pull-down level
  initial begin
    sck_out  = 1'b0;
    mosi_out = 1'b0;
    cs_n_out = 1'b1;
  end

  // one whole frame, msb first; reply bits are taken at each sck rise
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_out <= tx[i];
      repeat (HALF) @(posedge clk_in);
      sck_out <= 1'b1;
      rx[i] = miso_in;
      repeat (HALF) @(posedge clk_in);
      sck_out <= 1'b0;
    end
    repeat (HALF) @(posedge clk_in);
    cs_n_out <= 1'b1;
    mosi_out <= 1'b0;
    repeat (2 * HALF) @(posedge clk_in);
  endtask
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the accelerometer register bank
`timescale 1ns/1ps
`include "accel_reg_cfg.svh"

module tb_top;
  import accel_reg_pkg::*;
  localparam int unsigned MEM_CYC   = 40;
  localparam logic [7:0]  PART_INIT = 8'h3c;  // arbitrary value

  logic       clk_in, sys_rst_in, sck, mosi, cs_n, miso, miso_oe, miso_last;
  logic       overrange_flag, grav_done, grav_fail, run_fail, csum_bad, pd, sl, hc, gg, busy;
  sample_t    smp;
  int         err_total, checked, cyc, oe_cnt, n0;
  logic [7:0] ctrl_m, evt_m, part_m, st, d;
  logic       csum_m;
  logic [12:0] v;
  logic [7:0] wtab [9] = '{8'h00, 8'h40, 8'hb0, 8'h00, 8'h10, 8'h1a, 8'h24, 8'h00, 8'h0a};
  wire logic  miso_line = miso_oe ? miso : ~miso_last;

  spi_host_model host (.clk_in(clk_in), .miso_in(miso_line), .sck_out(sck), .mosi_out(mosi),
                       .cs_n_out(cs_n));

  accel_register_control #(.MEM_CHECK_CYCLES(MEM_CYC), .PART_CODE_INIT(PART_INIT)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sck_in(sck), .mosi_in(mosi), .cs_n_in(cs_n),
    .sample_in(smp), .saturated_in(overrange_flag), .gravity_done_in(grav_done),
    .gravity_fail_in(grav_fail), .running_fail_in(run_fail), .checksum_bad_in(csum_bad),
    .miso_out(miso), .miso_oe_out(miso_oe), .power_down_out(pd), .sleep_out(sl),
    .health_check_out(hc), .gravity_go_out(gg), .memory_check_busy_out(busy));

  // clock generation
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // released line floats away from its last value; drive cycles are counted; hang guard
  always @(posedge clk_in) begin
    if (miso_oe === 1'b1) begin
      miso_last <= miso;
      oe_cnt++;
    end
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // control write as the interlocks allow it
  function automatic logic [7:0] ctrl_f(input logic [7:0] c, input logic [7:0] w);
    logic [7:0] n;
    n    = {1'b0, c[6] & w[6], w[5], 4'h0, w[0]};
    n[4] = w[4] & ~(c[5] | w[5]);
    n[2] = w[2] & ~(c[5] | c[4] | w[5] | n[4]);
    n[3] = w[3] & ~(c[5] | c[4] | c[2] | w[5] | n[4] | n[2]);
    n[1] = w[1] & ~(c[5] | c[4] | c[2] | w[5] | n[4] | n[2]);
    return n;
  endfunction

  // status byte expected at the start of a frame
  function automatic logic [7:0] st_f();
    return {1'b0, evt_m[6], evt_m[5] | evt_m[4] | csum_m, 1'b0, ctrl_m[6], 3'b000};
  endfunction

  task automatic rd(input logic [5:0] a);
    logic [15:0] r;
    host.xfer({a, 2'b00, 8'h00}, r);
    st = r[15:8];
    d  = r[7:0];
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] val);
    logic [15:0] r;
    host.xfer({a, 2'b10, val}, r);
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] s;
    s = st_f();
    rd(a);
    chk("status", s, st);
    chk("data", exp, d);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clk_in);
    chk("busy_end", 8'h00, {7'h0, busy});
  endtask

  // main sequence
  initial begin
    void'($urandom(70));
    {overrange_flag, grav_done, grav_fail, run_fail, csum_bad} = '0;
    smp = '0;
    {err_total, checked, cyc, oe_cnt} = '0;
    miso_last = 1'b0;
    {ctrl_m, evt_m, part_m, csum_m} = {8'h40, 8'h40, PART_INIT, 1'b0};
    sys_rst_in = 1'b1;
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    chk("busy_start", 8'h01, {7'h0, busy});
    wait_idle();
    rchk(`ADDR_CTRL, ctrl_m);
    rchk(`ADDR_EVENT, evt_m);
    evt_m = 8'h00;
    rchk(`ADDR_EVENT, evt_m);
    rchk(`ADDR_PART_CODE, part_m);
    part_m = 8'($urandom);
    wr(`ADDR_PART_CODE, part_m);
    rchk(`ADDR_PART_CODE, part_m);
    // short saturation and running failure, both gone before the read
    overrange_flag <= 1'b1;
    run_fail <= 1'b1;
    @(posedge clk_in);
    overrange_flag <= 1'b0;
    run_fail <= 1'b0;
    repeat (4) @(posedge clk_in);
    evt_m = 8'h50;
    rchk(`ADDR_EVENT, evt_m);
    evt_m = 8'h00;
    rchk(`ADDR_EVENT, evt_m);
    // high byte first; the low byte must come from the same sample
    for (int k = 0; k < 4; k++) begin
      smp <= {13'($urandom), 13'($urandom), 13'($urandom), 13'($urandom)};
      repeat (2) @(posedge clk_in);
      v = smp[51 - 13 * k -: 13];
      rchk(k == 3 ? `ADDR_THERMO_HI : 6'(`ADDR_X_MSB + 2 * k),
           {2'b00, v[12:7]});
      smp <= {13'($urandom), 13'($urandom), 13'($urandom), 13'($urandom)};
      rchk(k == 3 ? `ADDR_THERMO_LO : 6'(`ADDR_X_LSB + 2 * k),
           {v[6:0], 1'b0});
    end
    // control writes through the interlocks
    foreach (wtab[i]) begin
      wr(`ADDR_CTRL, wtab[i]);
      ctrl_m = ctrl_f(ctrl_m, wtab[i]);
      rchk(`ADDR_CTRL, ctrl_m);
      chk("ctrl_pins", {4'h0, ctrl_m[5:3], ctrl_m[1]},
          {4'h0, pd, sl, hc, gg});
    end
    grav_done <= 1'b1;
    grav_fail <= 1'b1;
    @(posedge clk_in);
    grav_done <= 1'b0;
    grav_fail <= 1'b0;
    repeat (4) @(posedge clk_in);
    ctrl_m[1] = 1'b0;
    evt_m[5] = 1'b1;
    rchk(`ADDR_CTRL, ctrl_m);
    rchk(`ADDR_EVENT, evt_m);
    evt_m = 8'h00;
    // memory check: other bits cleared first, failing checksum reported at its end
    wr(`ADDR_CTRL, 8'h00);
    ctrl_m = 8'h00;
    csum_bad <= 1'b1;
    wr(`ADDR_CTRL, 8'h0e);
    ctrl_m = ctrl_f(ctrl_m, 8'h0e);
    chk("busy_run", 8'h01, {7'h0, busy});
    // a frame started while the check runs is ignored entirely
    n0 = oe_cnt;
    wr(`ADDR_CTRL, 8'h20);
    chk("busy_refuse", 8'h00, 8'(oe_cnt - n0));
    wait_idle();
    ctrl_m[2] = 1'b0;
    csum_m = 1'b1;
    rchk(`ADDR_CTRL, ctrl_m);
    rchk(`ADDR_STATUS, {6'h00, csum_m, 1'b0});
    // isolated output stays released even within a frame
    wr(`ADDR_CTRL, 8'h01);
    ctrl_m = 8'h01;
    n0 = oe_cnt;
    rd(`ADDR_CTRL);
    chk("drive_iso", 8'h00, 8'(oe_cnt - n0));
    wr(`ADDR_CTRL, 8'h00);
    ctrl_m = 8'h00;
    n0 = oe_cnt;
    rchk(`ADDR_CTRL, ctrl_m);
    chk("drive_norm", 8'h01, {7'h0, oe_cnt != n0});
    chk("idle_oe", 8'h00, {7'h0, miso_oe});
    results();
  end
endmodule
